// ---- src/dsp_defs.vh ----
`ifndef DSP_DEFS_VH
`define DSP_DEFS_VH
// register byte addresses
`define DSP_ADDR_MODE      32'hffffe800
`define DSP_ADDR_REFRESH   32'hffffe804
`define DSP_ADDR_CONFIG    32'hffffe808
`define DSP_ADDR_TIMING0   32'hffffe80c
`define DSP_ADDR_TIMING1   32'hffffe810
`define DSP_ADDR_TIMING2   32'hffffe814
`define DSP_ADDR_MEMDEV    32'hffffe820
`define DSP_ADDR_DLL       32'h0fffe824
`define DSP_ADDR_HS        32'hffffe82c
`define DSP_ADDR_WPMR      32'h0fffe8e4
`define DSP_ADDR_WPSR      32'h0fffe8e8
`define DSP_ADDR_IRQ_STAT  32'hffffe8f0
`define DSP_ADDR_IRQ_MASK  32'hffffe8f4
// fields
`define DSP_DLL_INC_BIT    0
`define DSP_DLL_DEC_BIT    1
`define DSP_DLL_OVF_BIT    2
`define DSP_DLL_VAL_LSB    8
`define DSP_DLL_VAL_W      8
`define DSP_DLL_VAL_MAX    8'hff
`define DSP_HS_ANTICIP_BIT 2
`define DSP_HS_RESET       32'h00000004
`define DSP_WP_EN_BIT      0
`define DSP_WP_KEY_LSB     8
`define DSP_WP_KEY         24'h444452
`define DSP_WPS_SRC_LSB    8
`define DSP_WPS_SRC_W      16
// interrupt status bits
`define DSP_IRQ_VIOL_BIT   0
`define DSP_IRQ_OVF_BIT    1
`define DSP_IRQ_LOCK_BIT   2
`define DSP_IRQ_W          3
// reset values of protected storage
`define DSP_MODE_RESET     32'h00000000
`define DSP_MEMDEV_RESET   32'h00000010
`endif

// ---- src/dsp_status_protect.v ----
`timescale 1ns/100ps
`include "dsp_defs.vh"
module dsp_status_protect (
  input  wire        sys_clk,
  input  wire        rst,
  input  wire [31:0] reg_addr,
  input  wire [31:0] reg_wdata,
  input  wire        reg_wr_stb,
  input  wire        reg_rd_stb,
  output reg  [31:0] reg_rdata,
  input  wire        dll_phase_late,
  input  wire        dll_phase_early,
  input  wire        dqs_in,
  output wire        dqs_delayed,
  output reg  [7:0]  dqs_delay_sel,
  output wire        read_anticip_en,
  output wire        protect_on,
  output wire [31:0] mode_cfg,
  output wire [31:0] refresh_cfg,
  output wire [31:0] config_cfg,
  output wire [31:0] timing0_cfg,
  output wire [31:0] timing1_cfg,
  output wire [31:0] timing2_cfg,
  output wire [31:0] memdev_cfg,
  output wire        irq
);

  function is_protected;
    input [31:0] a;
    begin
      is_protected = (a == `DSP_ADDR_MODE)    || (a == `DSP_ADDR_REFRESH) ||
                     (a == `DSP_ADDR_CONFIG)  || (a == `DSP_ADDR_TIMING0) ||
                     (a == `DSP_ADDR_TIMING1) || (a == `DSP_ADDR_TIMING2) ||
                     (a == `DSP_ADDR_MEMDEV)  || (a == `DSP_ADDR_HS);
    end
  endfunction

  // write strobe aimed at one register address
  function wr_to;
    input        stb;
    input [31:0] a;
    input [31:0] target;
    begin
      wr_to = stb & (a == target);
    end
  endfunction

  // index of a protected register in the storage array, 7 for the high-speed one
  function [2:0] prot_index;
    input [31:0] a;
    begin
      case (a)
        `DSP_ADDR_MODE:    prot_index = 3'h0;
        `DSP_ADDR_REFRESH: prot_index = 3'h1;
        `DSP_ADDR_CONFIG:  prot_index = 3'h2;
        `DSP_ADDR_TIMING0: prot_index = 3'h3;
        `DSP_ADDR_TIMING1: prot_index = 3'h4;
        `DSP_ADDR_TIMING2: prot_index = 3'h5;
        `DSP_ADDR_MEMDEV:  prot_index = 3'h6;
        default:           prot_index = 3'h7;
      endcase
    end
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // pin synchronisers: three stages, a change counts once stages 2 and 3 agree

  reg [1:0] pin_s1_reg;
  reg [1:0] pin_s2_reg;
  reg [1:0] pin_s3_reg;
  reg [1:0] pin_filt_reg;
  wire [1:0] pin_filt_next;

  genvar g;
  generate
    for (g = 0; g < 2; g = g + 1) begin : g_filt
      assign pin_filt_next[g] = (pin_s2_reg[g] == pin_s3_reg[g]) ?
                                pin_s3_reg[g] : pin_filt_reg[g];
    end
  endgenerate

  always @(posedge sys_clk) begin
    if (rst) begin
      pin_s1_reg   <= 2'h0;
      pin_s2_reg   <= 2'h0;
      pin_s3_reg   <= 2'h0;
      pin_filt_reg <= 2'h0;
    end else begin
      pin_s1_reg   <= {dll_phase_early, dll_phase_late};
      pin_s2_reg   <= pin_s1_reg;
      pin_s3_reg   <= pin_s2_reg;
      pin_filt_reg <= pin_filt_next;
    end
  end

  wire want_inc = pin_filt_reg[0] & ~pin_filt_reg[1];
  wire want_dec = pin_filt_reg[1] & ~pin_filt_reg[0];

  ////////////////////////////////////////////////////////////////////////////
  // master delay counter

  reg [7:0] dly_cnt_reg;
  reg       inc_flag_reg;
  reg       dec_flag_reg;
  reg       ovf_reg;
  reg       locked_reg;
  wire      at_max  = (dly_cnt_reg == `DSP_DLL_VAL_MAX);
  wire      do_inc  = want_inc & ~at_max & ~ovf_reg;
  wire      do_dec  = want_dec & (dly_cnt_reg != 8'h00);
  wire      hit_max = want_inc & at_max & ~ovf_reg;
  // lock is reached when the phase detector reports neither early nor late, or when an increment is asked at the maximum
  wire      settle  = ~pin_filt_reg[0] & ~pin_filt_reg[1];
  wire      ev_lock = ~locked_reg & (settle | hit_max);

  always @(posedge sys_clk) begin
    if (rst) begin
      dly_cnt_reg  <= 8'h00;
      inc_flag_reg <= 1'b0;
      dec_flag_reg <= 1'b0;
      ovf_reg      <= 1'b0;
      locked_reg   <= 1'b0;
    end else begin
      inc_flag_reg <= do_inc;
      dec_flag_reg <= do_dec;
      if (do_inc)
        dly_cnt_reg <= dly_cnt_reg + 8'h01;
      else if (do_dec)
        dly_cnt_reg <= dly_cnt_reg - 8'h01;
      if (hit_max) begin
        ovf_reg    <= 1'b1;
        locked_reg <= 1'b1;
      end else if (do_dec) begin
        ovf_reg    <= 1'b0;
      end
      if (settle)
        locked_reg <= 1'b1;
    end
  end

  // overflow only shows once locked and at maximum
  wire ovf_view = ovf_reg & locked_reg & at_max;

  // the tap select drives the external strobe delay line; the local copy
  // below only gates the strobe until a tap is settled
  always @(posedge sys_clk) begin
    if (rst)
      dqs_delay_sel <= 8'h00;
    else if (locked_reg)
      dqs_delay_sel <= dly_cnt_reg;
  end
  assign dqs_delayed = dqs_in & locked_reg;

  ////////////////////////////////////////////////////////////////////////////
  // protected configuration storage

  reg  [31:0] prot_mem [0:6];
  reg  [31:0] hs_reg;
  reg         wp_en_reg;
  reg         viol_reg;
  reg  [15:0] viol_src_reg;
  reg  [`DSP_IRQ_W-1:0] irq_stat_reg;
  reg  [`DSP_IRQ_W-1:0] irq_mask_reg;

  wire        wr_prot   = reg_wr_stb & is_protected(reg_addr);
  wire        refused   = wr_prot & wp_en_reg;
  wire        accepted  = wr_prot & ~wp_en_reg;
  wire [2:0]  pidx      = prot_index(reg_addr);
  wire        key_ok    = (reg_wdata[31:`DSP_WP_KEY_LSB] == `DSP_WP_KEY);
  wire        wpsr_read = reg_rd_stb & (reg_addr == `DSP_ADDR_WPSR);

  integer i;
  always @(posedge sys_clk) begin
    if (rst) begin
      for (i = 0; i < 7; i = i + 1)
        prot_mem[i] <= `DSP_MODE_RESET;
      hs_reg <= `DSP_HS_RESET;
    end else if (accepted) begin
      // a refused write never reaches here, so storage keeps its value
      if (pidx == 3'h7)
        hs_reg <= reg_wdata;
      else
        prot_mem[pidx] <= reg_wdata;
    end
  end

  wire [31:0] memdev_view = (prot_mem[6] == `DSP_MODE_RESET) ?
                            `DSP_MEMDEV_RESET : prot_mem[6];

  assign mode_cfg        = prot_mem[0];
  assign refresh_cfg     = prot_mem[1];
  assign config_cfg      = prot_mem[2];
  assign timing0_cfg     = prot_mem[3];
  assign timing1_cfg     = prot_mem[4];
  assign timing2_cfg     = prot_mem[5];
  assign memdev_cfg      = memdev_view;
  assign read_anticip_en = ~hs_reg[`DSP_HS_ANTICIP_BIT];
  assign protect_on      = wp_en_reg;

  ////////////////////////////////////////////////////////////////////////////
  // protection enable and violation status

  always @(posedge sys_clk) begin
    if (rst) begin
      wp_en_reg <= 1'b0;
    end else if (wr_to(reg_wr_stb, reg_addr, `DSP_ADDR_WPMR) && key_ok) begin
      wp_en_reg <= reg_wdata[`DSP_WP_EN_BIT];
    end
  end

  // a violation and a status read cannot share a cycle on this bus,
  // but the set is written last so it would win anyway
  always @(posedge sys_clk) begin
    if (rst) begin
      viol_reg     <= 1'b0;
      viol_src_reg <= 16'h0000;
    end else begin
      if (wpsr_read) begin
        viol_reg     <= 1'b0;
        viol_src_reg <= 16'h0000;
      end
      if (refused) begin
        viol_reg     <= 1'b1;
        viol_src_reg <= reg_addr[15:0];
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // interrupts: sticky events, write one to clear, set wins

  wire [`DSP_IRQ_W-1:0] irq_events = {ev_lock, hit_max, refused};
  wire [`DSP_IRQ_W-1:0] irq_clr    =
    wr_to(reg_wr_stb, reg_addr, `DSP_ADDR_IRQ_STAT) ?
    reg_wdata[`DSP_IRQ_W-1:0] : {`DSP_IRQ_W{1'b0}};

  always @(posedge sys_clk) begin
    if (rst) begin
      irq_stat_reg <= {`DSP_IRQ_W{1'b0}};
      irq_mask_reg <= {`DSP_IRQ_W{1'b0}};
    end else begin
      irq_stat_reg <= (irq_stat_reg & ~irq_clr) | irq_events;
      if (wr_to(reg_wr_stb, reg_addr, `DSP_ADDR_IRQ_MASK))
        irq_mask_reg <= reg_wdata[`DSP_IRQ_W-1:0];
    end
  end

  assign irq = |(irq_stat_reg & irq_mask_reg);

  ////////////////////////////////////////////////////////////////////////////
  // read path: data stands in the cycle after the strobe only

  reg [31:0] rd_next;
  always @* begin
    rd_next = 32'h00000000;
    case (reg_addr)
      `DSP_ADDR_MODE:    rd_next = prot_mem[0];
      `DSP_ADDR_REFRESH: rd_next = prot_mem[1];
      `DSP_ADDR_CONFIG:  rd_next = prot_mem[2];
      `DSP_ADDR_TIMING0: rd_next = prot_mem[3];
      `DSP_ADDR_TIMING1: rd_next = prot_mem[4];
      `DSP_ADDR_TIMING2: rd_next = prot_mem[5];
      `DSP_ADDR_MEMDEV:  rd_next = memdev_view;
      `DSP_ADDR_HS:      rd_next = hs_reg;
      `DSP_ADDR_DLL: begin
        rd_next[`DSP_DLL_INC_BIT] = inc_flag_reg;
        rd_next[`DSP_DLL_DEC_BIT] = dec_flag_reg;
        rd_next[`DSP_DLL_OVF_BIT] = ovf_view;
        rd_next[`DSP_DLL_VAL_LSB+:`DSP_DLL_VAL_W] = dly_cnt_reg;
      end
      // key field stays zero
      `DSP_ADDR_WPMR:    rd_next[`DSP_WP_EN_BIT] = wp_en_reg;
      `DSP_ADDR_WPSR: begin
        rd_next[0] = viol_reg;
        rd_next[`DSP_WPS_SRC_LSB+:`DSP_WPS_SRC_W] = viol_src_reg;
      end
      `DSP_ADDR_IRQ_STAT: rd_next[`DSP_IRQ_W-1:0] = irq_stat_reg;
      `DSP_ADDR_IRQ_MASK: rd_next[`DSP_IRQ_W-1:0] = irq_mask_reg;
      default:           rd_next = 32'h00000000;
    endcase
  end

  always @(posedge sys_clk) begin
    if (rst)
      reg_rdata <= 32'h00000000;
    else if (reg_rd_stb)
      reg_rdata <= rd_next;
    else
      reg_rdata <= 32'h00000000;
  end

endmodule // dsp_status_protect

// ---- tb/dsp_status_protect_bench.sv ----
`timescale 1ns/100ps
`include "dsp_defs.vh"
module dsp_status_protect_bench;
  logic        sys_clk = 0;
  logic        rst = 1;
  logic [31:0] reg_addr = 0;
  logic [31:0] reg_wdata = 0;
  logic        reg_wr_stb = 0;
  logic        reg_rd_stb = 0;
  logic        dll_phase_late = 0;
  logic        dll_phase_early = 0;
  logic        dqs_in = 0;
  wire  [31:0] reg_rdata, mode_cfg, memdev_cfg;
  wire  [31:0] refresh_cfg, config_cfg, timing0_cfg, timing1_cfg, timing2_cfg;
  wire  [7:0]  dly_sel;
  wire         dqs_delayed, read_anticip_en, protect_on, irq;
  logic        pend = 0;
  logic [31:0] pexp = 0, pmask = 0;
  int          errors = 0, cmp_count = 0;
  logic [31:0] pa [8] = '{`DSP_ADDR_MODE, `DSP_ADDR_REFRESH, `DSP_ADDR_CONFIG, `DSP_ADDR_TIMING0,
                          `DSP_ADDR_TIMING1, `DSP_ADDR_TIMING2, `DSP_ADDR_MEMDEV, `DSP_ADDR_HS};
  logic [31:0] pv [8] = '{0, 0, 0, 0, 0, 0, `DSP_MEMDEV_RESET, 0};
  dsp_status_protect dsp_status_protect_i (
    .sys_clk(sys_clk), .rst(rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr_stb(reg_wr_stb), .reg_rd_stb(reg_rd_stb), .reg_rdata(reg_rdata),
    .dll_phase_late(dll_phase_late), .dll_phase_early(dll_phase_early), .dqs_in(dqs_in),
    .dqs_delayed(dqs_delayed), .dqs_delay_sel(dly_sel), .read_anticip_en(read_anticip_en),
    .protect_on(protect_on), .mode_cfg(mode_cfg), .refresh_cfg(refresh_cfg),
    .config_cfg(config_cfg), .timing0_cfg(timing0_cfg), .timing1_cfg(timing1_cfg),
    .timing2_cfg(timing2_cfg), .memdev_cfg(memdev_cfg), .irq(irq));
  always #4 sys_clk = ~sys_clk;
  ////////////////////////////////////////////////////////////////////////////
  task chk(input string n, input logic [31:0] s, e);
    cmp_count++;
    if (s !== e) begin
      errors++;
      $display("[ERR] %s expected %h seen %h", n, e, s);
    end
  endtask
  task test_done;
    $display("checks %0d errors %0d", cmp_count, errors);
    if (errors == 0 && cmp_count > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  // one bus cycle per call; strobes are held or dropped by the next call, never twice a step
  task op(input logic w, r, input logic [31:0] a, d, m, e);
    @(posedge sys_clk);
    reg_wr_stb <= w;
    reg_rd_stb <= r;
    reg_addr <= a;
    reg_wdata <= d;
    pend <= r;
    pmask <= m;
    pexp <= e;
  endtask
  task wr(input logic [31:0] a, d);
    op(1, 0, a, d, 0, 0);
  endtask
  task rd(input logic [31:0] a, m, e);
    op(0, 1, a, 0, m, e);
  endtask
  task idle;
    op(0, 0, 0, 0, 0, 0);
  endtask
  // read data stands only in the cycle after the strobe, so the request is latched here
  always @(posedge sys_clk) begin : rd_check
    logic        p;
    logic [31:0] e, m;
    p = pend;
    e = pexp;
    m = pmask;
    #1;
    if (p)
      chk("rdata", reg_rdata & m, e);
  end
  initial begin
    repeat (2000) @(posedge sys_clk);
    errors++;
    test_done;
  end
  ////////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (5) @(posedge sys_clk);
    rst <= 0;
    rd(`DSP_ADDR_HS, 32'hffffffff, `DSP_HS_RESET);
    wr(`DSP_ADDR_HS, 32'h0); // buffer placement across banks is left to software
    idle;
    #1 chk("anticip", read_anticip_en, 1);
    wr(`DSP_ADDR_WPMR, 32'h44445301);
    rd(`DSP_ADDR_WPMR, 32'hffffffff, 32'h0);
    wr(`DSP_ADDR_WPMR, 32'h44445201);
    rd(`DSP_ADDR_WPMR, 32'hffffffff, 32'h1);
    wr(`DSP_ADDR_IRQ_MASK, 32'h1);
    for (int i = 0; i < 8; i++) begin
      wr(pa[i], 32'h55);
      rd(`DSP_ADDR_WPSR, 32'hffffffff, {8'h0, pa[i][15:0], 8'h01});
    end
    rd(`DSP_ADDR_WPSR, 32'hffffffff, 32'h0);
    idle;
    #1 chk("irq", irq, 1);
    chk("cfg", refresh_cfg | config_cfg | timing0_cfg | timing1_cfg | timing2_cfg, 0);
    chk("memdev", memdev_cfg, `DSP_MEMDEV_RESET);
    wr(`DSP_ADDR_IRQ_MASK, 32'h0);
    idle;
    #1 chk("irq", irq, 0);
    wr(`DSP_ADDR_IRQ_MASK, 32'h1);
    wr(`DSP_ADDR_IRQ_STAT, 32'h1);
    idle;
    #1 chk("irq", irq, 0);
    for (int i = 0; i < 8; i++)
      rd(pa[i], 32'hffffffff, pv[i]);
    wr(`DSP_ADDR_WPMR, 32'h44445200);
    wr(`DSP_ADDR_MODE, 32'h55);
    idle;
    #1 chk("mode", mode_cfg, 32'h55);
    rd(32'hffffe8fc, 32'hffffffff, 32'h0);
    dll_phase_late <= 1;
    repeat (10) idle;
    rd(`DSP_ADDR_DLL, 32'h7, 32'h1);
    repeat (300) idle;
    rd(`DSP_ADDR_DLL, 32'hff07, 32'hff04);
    dqs_in <= 1;
    idle;
    #1 chk("dqs", dqs_delayed, 1);
    chk("tap", {24'h0, dly_sel}, 32'hff);
    dll_phase_late <= 0;
    dll_phase_early <= 1;
    repeat (10) idle;
    rd(`DSP_ADDR_DLL, 32'h7, 32'h2);
    idle;
    idle;
    test_done;
  end
endmodule // dsp_status_protect_bench

// ---- tb/dsp_status_protect_properties.sv ----
`timescale 1ns/100ps
`include "dsp_defs.vh"
module dsp_status_protect_chk (
  input logic        sys_clk,
  input logic        rst,
  input logic [31:0] reg_addr,
  input logic [31:0] reg_wdata,
  input logic        reg_wr_stb,
  input logic        reg_rd_stb,
  input logic [31:0] reg_rdata,
  input logic        protect_on,
  input logic [31:0] mode_cfg,
  input logic        read_anticip_en
);
  wire wr_wpmr = reg_wr_stb && reg_addr == `DSP_ADDR_WPMR;
  wire key_ok  = reg_wdata[31:8] == `DSP_WP_KEY;
  wire rd_wpsr = reg_rd_stb && reg_addr == `DSP_ADDR_WPSR;
  wire rd_dll  = reg_rd_stb && reg_addr == `DSP_ADDR_DLL;
  wire wr_mode = protect_on && reg_wr_stb && reg_addr == `DSP_ADDR_MODE;
  default clocking @(posedge sys_clk); endclocking
  default disable iff (rst);
  ////////////////////////////////////////////////////////////////////////////
  property p_set;
    logic b;
    (wr_wpmr && key_ok, b = reg_wdata[0]) |=> protect_on == b;
  endproperty
  // a refused write must not touch the anticipation bit, so only unprotected writes count
  property p_hs;
    logic b;
    (reg_wr_stb && reg_addr == `DSP_ADDR_HS && !protect_on, b = reg_wdata[2])
      |=> read_anticip_en == !b;
  endproperty
  a_key_enable: assert property (p_set)
    else $error("protect enable not taken from keyed write");
  a_bad_key: assert property (wr_wpmr && !key_ok |=> $stable(protect_on))
    else $error("protect enable changed by wrong key");
  a_key_zero: assert property (reg_rd_stb && reg_addr == `DSP_ADDR_WPMR |=> reg_rdata[31:8] == 24'h0)
    else $error("key field read not zero");
  a_refuse_write: assert property (wr_mode |=> $stable(mode_cfg))
    else $error("protected mode register changed");
  a_viol_source: assert property (wr_mode ##1 rd_wpsr |=> reg_rdata[0] && reg_rdata[23:8] == 16'he800)
    else $error("violation flag or source wrong");
  a_status_clear: assert property (rd_wpsr ##1 rd_wpsr |=> reg_rdata == 32'h0)
    else $error("protect status not cleared by read");
  a_anticip_bit: assert property (p_hs)
    else $error("anticipation enable mismatch");
  a_ovf_view: assert property (rd_dll |=> !reg_rdata[2] || reg_rdata[15:8] == `DSP_DLL_VAL_MAX)
    else $error("overflow flag below maximum");
  a_step_flags: assert property (rd_dll |=> !(reg_rdata[0] && reg_rdata[1]))
    else $error("increment and decrement both set");
  cover property (wr_mode);
  cover property (rd_dll ##1 reg_rdata[2]);
  cover property (rd_wpsr ##1 reg_rdata[0]);
endmodule // dsp_status_protect_chk
bind dsp_status_protect dsp_status_protect_chk dsp_status_protect_chk_i (
  .sys_clk(sys_clk), .rst(rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
  .reg_wr_stb(reg_wr_stb), .reg_rd_stb(reg_rd_stb), .reg_rdata(reg_rdata),
  .protect_on(protect_on), .mode_cfg(mode_cfg), .read_anticip_en(read_anticip_en));
